// file: design/tcp_consts.vh
// Purpose: shared constants for the timer/counter/pwm block
// Assumes: included by bare name from design files
// Notes: byte addresses of the AXI4-Lite register map
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH

// register byte addresses
`define TCP_A_CTRL 8'h00
`define TCP_A_PERIOD 8'h04
`define TCP_A_COMPARE 8'h08
`define TCP_A_COUNT 8'h0C
`define TCP_A_CAPTURE 8'h10
`define TCP_A_DEADBAND 8'h14
`define TCP_A_PRESCALE 8'h18
`define TCP_A_INTSTAT 8'h1C
`define TCP_A_INTMASK 8'h20
`define TCP_A_STATUS 8'h24

// control register fields
`define TCP_C_EN 0
`define TCP_C_MODE_LO 1
`define TCP_C_MODE_HI 2
`define TCP_C_CMP_LO 3
`define TCP_C_CMP_HI 5
`define TCP_C_CLK_LO 6
`define TCP_C_CLK_HI 7
`define TCP_C_COMPL 8
`define TCP_C_START 9

// counting modes
`define TCP_MODE_FREE 2'h0
`define TCP_MODE_ONESHOT 2'h1
`define TCP_MODE_GATED 2'h2

// comparator relations
`define TCP_CMP_LESS_THAN 3'h0
`define TCP_CMP_LESS_OR_EQUAL 3'h1
`define TCP_CMP_EQUAL_TO 3'h2
`define TCP_CMP_GREATER_OR_EQUAL 3'h3
`define TCP_CMP_GREATER_THAN 3'h4

// count clock sources
`define TCP_CLK_SYS 2'h0
`define TCP_CLK_PRESCALE 2'h1
`define TCP_CLK_EXT 2'h2
`define TCP_CLK_EXT_FALL 2'h3

// interrupt bits
`define TCP_I_TC 0
`define TCP_I_CMP 1
`define TCP_I_CAP 2

// reset values
`define TCP_RST_CTRL 10'h000
`define TCP_RST_PERIOD 16'hFFFF
`define TCP_RST_COMPARE 16'h8000
`define TCP_RST_DEADBAND 8'h00
`define TCP_RST_PRESCALE 16'h0000

// axi responses
`define TCP_RESP_OKAY 2'h0
`define TCP_RESP_SLVERR 2'h2

`endif

// file: design/tcp_deadband.v
// Purpose: complementary output pair with dead-band gap
// Assumes: tick marks one count clock; ref is the compare level
// Notes: both outputs low during each gap and while kill is high
`timescale 1ns/1ps
`default_nettype none
module tcp_deadband #(
	parameter DBW = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire tick,
	input wire ref_in,
	input wire kill,
	input wire [DBW-1:0] db_len,
	output wire pwm_p,
	output wire pwm_n
);
	reg last_ff;
	reg [DBW-1:0] gap_ff;
	reg p_ff;
	reg n_ff;
	reg [DBW-1:0] nxt_gap;
	reg nxt_p;
	reg nxt_n;

	always @* begin
		nxt_gap = gap_ff;
		nxt_p = p_ff;
		nxt_n = n_ff;
		if (ref_in != last_ff) begin
			nxt_gap = db_len;
			nxt_p = 1'b0;
			nxt_n = 1'b0;
		end else if (gap_ff != {DBW{1'b0}}) begin
			if (tick) begin
				nxt_gap = gap_ff - {{(DBW-1){1'b0}}, 1'b1};
			end
		end else begin
			nxt_p = last_ff;
			nxt_n = ~last_ff;
		end
	end

	// state update, frozen while ce is low
	always @(posedge aclk) begin
		if (!aresetn) begin
			last_ff <= 1'b0;
			gap_ff <= {DBW{1'b0}};
			p_ff <= 1'b0;
			n_ff <= 1'b0;
		end else if (ce) begin
			last_ff <= ref_in;
			gap_ff <= nxt_gap;
			p_ff <= nxt_p;
			n_ff <= nxt_n;
		end
	end

	assign pwm_p = p_ff & ~kill;
	assign pwm_n = n_ff & ~kill;
endmodule // tcp_deadband
`default_nettype wire

// file: design/tcp_timer.v
// Purpose: 16-bit down-counting timer, counter and pwm unit
// Assumes: all inputs synchronous to aclk; AXI4-Lite register access
// Notes: count clock is a one-cycle tick derived from the chosen source
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_consts.vh"

// Overview of operation
// - sixteen-bit counter, counts down only
// - software selects the count clock source
// - compare output uses selectable relation
// - period reloads on start, reset, terminal count
// - interrupt on terminal count, compare, capture
// - one-shot stops after one full period
// - gated mode counts only while enabled
// - compare and terminal count outputs, complementary option
// - complementary outputs separated by dead band
// - kill forces pwm outputs inactive
// - capture stores full counter value
module tcp_timer #(
	parameter CW = 16,
	parameter DBW = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_clk_in,
	input wire timer_reset_in,
	input wire capture_in,
	input wire enable_in,
	input wire kill_in,
	output wire compare_out,
	output wire tc_out,
	output wire pwm_p_out,
	output wire irq
);
	// state codes, one-hot
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	// registers, their next values and the write path nets
	reg [9:0] ctrl_ff;
	reg [CW-1:0] period_ff, compare_ff, count_ff, capture_ff, nxt_count;
	reg [DBW-1:0] db_ff;
	reg [15:0] presc_ff, pdiv_ff, nxt_pdiv;
	reg [2:0] istat_ff, imask_ff, state_ff, nxt_state;
	reg ext_q_ff, cap_q_ff, rst_q_ff, cmp_ff, tc_ff, en_q_ff, start_ff, nxt_tc, tc_evt, tick;
	reg aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	reg [7:0] aw_addr_ff;
	reg [31:0] w_data_ff, rdata_ff;
	reg [3:0] w_strb_ff;
	reg [1:0] bresp_ff, rresp_ff;
	wire [3:0] wr_strb;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [2:0] hw_set;
	wire do_write, cap_evt, rst_evt, gate_ok, cmp_now, pwm_n;

	// merge byte lanes into an old word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	function cmp_rel;
		input [2:0] sel;
		input [CW-1:0] cnt;
		input [CW-1:0] cmpv;
		begin
			case (sel)
				`TCP_CMP_LESS_THAN: cmp_rel = cnt < cmpv;
				`TCP_CMP_LESS_OR_EQUAL: cmp_rel = cnt <= cmpv;
				`TCP_CMP_EQUAL_TO: cmp_rel = cnt == cmpv;
				`TCP_CMP_GREATER_OR_EQUAL: cmp_rel = cnt >= cmpv;
				`TCP_CMP_GREATER_THAN: cmp_rel = cnt > cmpv;
				default: cmp_rel = 1'b0;
			endcase
		end
	endfunction

	// write channel: address and data taken in either order
	assign s_axi_awready = ce & ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready = ce & ~w_hold_ff & ~bvalid_ff;
	assign wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
	assign wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
	assign wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
	assign do_write = ce & ~bvalid_ff & (aw_hold_ff | s_axi_awvalid) & (w_hold_ff | s_axi_wvalid);
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ce & ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// merged write words; upper lanes beyond a register's width are dropped on purpose
	wire [31:0] m_ctrl = merge({22'h0, ctrl_ff}, wr_data, wr_strb);
	wire [31:0] m_period = merge({16'h0, period_ff}, wr_data, wr_strb);
	wire [31:0] m_compare = merge({16'h0, compare_ff}, wr_data, wr_strb);
	wire [31:0] m_db = merge({24'h0, db_ff}, wr_data, wr_strb);
	wire [31:0] m_presc = merge({16'h0, presc_ff}, wr_data, wr_strb);

	// write handshake bookkeeping
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_hold_ff <= 1'b0;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `TCP_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= (wr_addr > `TCP_A_STATUS || wr_addr[1:0] != 2'h0) ? `TCP_RESP_SLVERR : `TCP_RESP_OKAY;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_hold_ff <= 1'b1;
					aw_addr_ff <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_hold_ff <= 1'b1;
					w_data_ff <= s_axi_wdata;
					w_strb_ff <= s_axi_wstrb;
				end
				if (s_axi_bready) begin
					bvalid_ff <= 1'b0;
				end
			end
		end
	end

	// read path, answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `TCP_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && !rvalid_ff) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= `TCP_RESP_OKAY;
				rdata_ff <= 32'h00000000;
				if (s_axi_araddr == `TCP_A_CTRL) begin
					rdata_ff[9:0] <= ctrl_ff;
				end else if (s_axi_araddr == `TCP_A_PERIOD) begin
					rdata_ff[CW-1:0] <= period_ff;
				end else if (s_axi_araddr == `TCP_A_COMPARE) begin
					rdata_ff[CW-1:0] <= compare_ff;
				end else if (s_axi_araddr == `TCP_A_COUNT) begin
					rdata_ff[CW-1:0] <= count_ff;
				end else if (s_axi_araddr == `TCP_A_CAPTURE) begin
					rdata_ff[CW-1:0] <= capture_ff;
				end else if (s_axi_araddr == `TCP_A_DEADBAND) begin
					rdata_ff[DBW-1:0] <= db_ff;
				end else if (s_axi_araddr == `TCP_A_PRESCALE) begin
					rdata_ff[15:0] <= presc_ff;
				end else if (s_axi_araddr == `TCP_A_INTSTAT) begin
					rdata_ff[2:0] <= istat_ff;
				end else if (s_axi_araddr == `TCP_A_INTMASK) begin
					rdata_ff[2:0] <= imask_ff;
				end else if (s_axi_araddr == `TCP_A_STATUS) begin
					rdata_ff[4:0] <= {tc_ff, cmp_ff, state_ff};
				end else begin
					rresp_ff <= `TCP_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// sticky events; a set wins over a write-one clear
	assign hw_set = {cap_evt, cmp_now & ~cmp_ff, tc_evt};
	assign irq = |(istat_ff & imask_ff);

	// software registers; start is a self-clearing pulse
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= `TCP_RST_CTRL;
			period_ff <= `TCP_RST_PERIOD;
			compare_ff <= `TCP_RST_COMPARE;
			db_ff <= `TCP_RST_DEADBAND;
			presc_ff <= `TCP_RST_PRESCALE;
			istat_ff <= 3'h0;
			imask_ff <= 3'h0;
		end else if (ce) begin
			ctrl_ff[`TCP_C_START] <= 1'b0;
			istat_ff <= istat_ff | hw_set;
			if (do_write) begin
				if (wr_addr == `TCP_A_CTRL) begin
					ctrl_ff <= m_ctrl[9:0];
				end else if (wr_addr == `TCP_A_PERIOD) begin
					period_ff <= m_period[CW-1:0];
				end else if (wr_addr == `TCP_A_COMPARE) begin
					compare_ff <= m_compare[CW-1:0];
				end else if (wr_addr == `TCP_A_DEADBAND) begin
					db_ff <= m_db[DBW-1:0];
				end else if (wr_addr == `TCP_A_PRESCALE) begin
					presc_ff <= m_presc[15:0];
				end else if (wr_addr == `TCP_A_INTSTAT) begin
					if (wr_strb[0]) begin
						istat_ff <= (istat_ff & ~wr_data[2:0]) | hw_set;
					end
				end else if (wr_addr == `TCP_A_INTMASK) begin
					if (wr_strb[0]) begin
						imask_ff <= wr_data[2:0];
					end
				end
			end
		end
	end

	always @* begin
		nxt_pdiv = pdiv_ff + 16'h0001;
		case (ctrl_ff[`TCP_C_CLK_HI:`TCP_C_CLK_LO])
			`TCP_CLK_SYS: tick = 1'b1;
			`TCP_CLK_PRESCALE: tick = (pdiv_ff == presc_ff);
			`TCP_CLK_EXT: tick = ext_clk_in & ~ext_q_ff;
			default: tick = ~ext_clk_in & ext_q_ff;
		endcase
		if (pdiv_ff == presc_ff) begin
			nxt_pdiv = 16'h0000;
		end
	end

	// inputs are taken as synchronous, edges seen in aclk
	assign cap_evt = capture_in & ~cap_q_ff;
	assign rst_evt = timer_reset_in & ~rst_q_ff;
	// gated mode needs the enable input
	assign gate_ok = (ctrl_ff[`TCP_C_MODE_HI:`TCP_C_MODE_LO] != `TCP_MODE_GATED) | enable_in;
	assign cmp_now = (state_ff != ST_IDLE) & cmp_rel(ctrl_ff[`TCP_C_CMP_HI:`TCP_C_CMP_LO], count_ff, compare_ff);

	// counter state machine
	always @* begin
		nxt_count = count_ff;
		nxt_state = state_ff;
		nxt_tc = tc_ff;
		tc_evt = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				nxt_tc = 1'b0;
				if (start_ff) begin
					nxt_count = period_ff;
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!ctrl_ff[`TCP_C_EN]) begin
					nxt_state = ST_IDLE;
					nxt_tc = 1'b0;
				end else if (rst_evt) begin
					nxt_count = period_ff;
					nxt_tc = 1'b0;
				end else if (tick && gate_ok) begin
					nxt_tc = 1'b0;
					if (count_ff == {CW{1'b0}}) begin
						nxt_count = period_ff;
						// one-shot stops at end of period
						if (ctrl_ff[`TCP_C_MODE_HI:`TCP_C_MODE_LO] == `TCP_MODE_ONESHOT) begin
							nxt_state = ST_DONE;
						end
					end else begin
						nxt_count = count_ff - {{(CW-1){1'b0}}, 1'b1};
						if (nxt_count == {CW{1'b0}}) begin
							nxt_tc = 1'b1;
							tc_evt = 1'b1;
						end
					end
				end
			end
			ST_DONE: begin
				nxt_tc = 1'b0;
				if (start_ff || rst_evt) begin
					nxt_count = period_ff;
					nxt_state = ST_RUN;
				end else if (!ctrl_ff[`TCP_C_EN]) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// counter, capture and edge history
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			count_ff <= {CW{1'b0}};
			capture_ff <= {CW{1'b0}};
			pdiv_ff <= 16'h0000;
			ext_q_ff <= 1'b0;
			cap_q_ff <= 1'b0;
			rst_q_ff <= 1'b0;
			cmp_ff <= 1'b0;
			tc_ff <= 1'b0;
			en_q_ff <= 1'b0;
			start_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			pdiv_ff <= nxt_pdiv;
			ext_q_ff <= ext_clk_in;
			cap_q_ff <= capture_in;
			rst_q_ff <= timer_reset_in;
			cmp_ff <= cmp_now;
			tc_ff <= nxt_tc;
			en_q_ff <= ctrl_ff[`TCP_C_EN];
			// start on enable rise or start bit while enabled
			start_ff <= ctrl_ff[`TCP_C_EN] & (~en_q_ff | ctrl_ff[`TCP_C_START]);
			if (cap_evt) begin
				capture_ff <= count_ff;
			end
		end
	end

	// dead-band pair driven from the compare level
	tcp_deadband #(.DBW(DBW)) tcp_deadband_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .tick(tick),
		.ref_in(cmp_ff), .kill(kill_in), .db_len(db_ff), .pwm_p(pwm_p_out), .pwm_n(pwm_n));

	// tc line may carry the complementary output
	assign tc_out = ctrl_ff[`TCP_C_COMPL] ? pwm_n : tc_ff;
	assign compare_out = cmp_ff & ~kill_in;
endmodule // tcp_timer
`default_nettype wire

// file: sim/tcp_fabric_model.sv
// Purpose: routing fabric stand-in for the timer control lines
// Assumes: bench calls one task at a time
// Notes: lines change only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tcp_fabric_model (
	input wire logic aclk,
	output logic ext_clk_in,
	output logic timer_reset_in,
	output logic capture_in,
	output logic enable_in,
	output logic kill_in
);
	// all lines quiet at time zero
	initial begin
		ext_clk_in = 1'h0;
		timer_reset_in = 1'h0;
		capture_in = 1'h0;
		enable_in = 1'h0;
		kill_in = 1'h0;
	end
	// one-cycle pulse on the capture line, or on the timer reset line when cap is low
	task automatic pulse(input logic cap);
		@(posedge aclk);
		if (cap) capture_in <= 1'h1;
		else timer_reset_in <= 1'h1;
		@(posedge aclk);
		capture_in <= 1'h0;
		timer_reset_in <= 1'h0;
	endtask
	// kill level moved on an edge
	task automatic set_kill(input logic v);
		@(posedge aclk);
		kill_in <= v;
	endtask
	// enable held for n sampling edges
	task automatic en_for(input int n);
		@(posedge aclk);
		enable_in <= 1'h1;
		repeat (n) @(posedge aclk);
		enable_in <= 1'h0;
	endtask
	// external edges; gap slows them, line idles low
	task automatic ext_ticks(input int n, input int gap);
		repeat (n) begin
			@(posedge aclk);
			ext_clk_in <= 1'h1;
			repeat (gap + 1) @(posedge aclk);
			ext_clk_in <= 1'h0;
			repeat (gap) @(posedge aclk);
		end
	endtask
endmodule // tcp_fabric_model
`default_nettype wire

// file: sim/tcp_timer_assertions.sv
// Purpose: port-level checks on the timer block
// Assumes: bound onto tcp_timer, single clock
// Notes: kill gating and register bus handshakes
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_chk (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire kill_in,
	input wire compare_out,
	input wire pwm_p_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_kill_cmp: assert property (kill_in |-> !compare_out)
		else $error("compare output high under kill");
	chk_kill_pwm: assert property (kill_in |-> !pwm_p_out)
		else $error("pwm output high under kill");
	// stalled clock enable must not accept bus traffic
	chk_ce_freeze: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while clock enable low");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	cov_kill: cover property ($fell(compare_out) && kill_in);
	cov_pwm: cover property ($rose(pwm_p_out));
	cov_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // tcp_timer_chk
bind tcp_timer tcp_timer_chk tcp_timer_chk_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .kill_in(kill_in), .compare_out(compare_out), .pwm_p_out(pwm_p_out));
`default_nettype wire

// file: sim/tcp_timer_tb_top.sv
// Purpose: self-checking bench for the timer block
// Assumes: fabric model drives the control lines
// Notes: expectations from integer arithmetic on chosen settings
`timescale 1ns/1ps
`default_nettype none
`include "tcp_consts.vh"
module tcp_timer_tb_top;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic ce = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, tc_q = 1'h0, compl_on = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] last_resp;
	wire awready, wready, bvalid, arready, rvalid, ext, trst, cap, en, kill, cmp, tc, pwm, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int err_total = 0, tests_run = 0, tc_cnt = 0, tc_gap = 0, since = 0, ovl = 0, low_run = 0, min_gap = 999, cyc = 0;
	int p, n, q, k, db, base;
	tcp_timer tcp_timer_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_clk_in(ext), .timer_reset_in(trst), .capture_in(cap), .enable_in(en), .kill_in(kill), .compare_out(cmp),
		.tc_out(tc), .pwm_p_out(pwm), .irq(irq));
	tcp_fabric_model tcp_fabric_model_i (.aclk(aclk), .ext_clk_in(ext), .timer_reset_in(trst), .capture_in(cap),
		.enable_in(en), .kill_in(kill));
	always #10 aclk = ~aclk;
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// both halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready) aw_ok = 1'h1;
			if (wready) w_ok = 1'h1;
			if (aw_ok) awvalid <= 1'h0;
			if (w_ok) wvalid <= 1'h0;
		end
		// late ready exercises the slave holding its answer
		@(posedge aclk);
		bready <= 1'h1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'h0;
		last_resp = bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		@(posedge aclk);
		rready <= 1'h1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'h0;
		d = rdata;
		last_resp = rresp;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a, rd);
		chk(what, exp, rd);
	endtask
	function automatic logic [31:0] exp_cmp(input int rel, input int c, input int v);
		case (rel)
			0: return c < v;
			1: return c <= v;
			2: return c == v;
			3: return c >= v;
			default: return c > v;
		endcase
	endfunction
	// tc spacing, pair overlap, dead gap and hang watch
	always @(posedge aclk) begin
		since++;
		if (tc && !tc_q) begin
			tc_gap = since;
			since = 0;
			tc_cnt++;
		end
		tc_q = tc;
		if (compl_on && pwm && tc) ovl++;
		if (compl_on && !pwm && !tc) low_run++;
		else begin
			if (low_run > 0 && low_run < min_gap) min_gap = low_run;
			low_run = 0;
		end
		if (++cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(56819));
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rchk("ctrl", `TCP_A_CTRL, `TCP_RST_CTRL);
		rchk("period", `TCP_A_PERIOD, `TCP_RST_PERIOD);
		rchk("compare", `TCP_A_COMPARE, `TCP_RST_COMPARE);
		rchk("hole", 8'h28, 32'h0);
		chk("hole rresp", `TCP_RESP_SLVERR, last_resp);
		wr(8'h28, 32'h1);
		chk("hole bresp", `TCP_RESP_SLVERR, last_resp);
		// gated mode with enable low keeps count at the period
		p = 100 + $urandom % 1000;
		wr(`TCP_A_PERIOD, p);
		wr(`TCP_A_CTRL, 32'h5);
		rchk("load", `TCP_A_COUNT, p);
		for (int rel = 0; rel < 5; rel++) begin
			for (int d = 0; d < 3; d++) begin
				wr(`TCP_A_COMPARE, p + d - 1);
				wr(`TCP_A_CTRL, 32'h5 | (rel << 3));
				rd_reg(`TCP_A_STATUS, rd);
				chk("cmp status", exp_cmp(rel, p, p + d - 1), rd[3]);
				chk("cmp out", exp_cmp(rel, p, p + d - 1), cmp);
			end
		end
		wr(`TCP_A_CTRL, 32'h5);
		chk("cmp lt", 1, cmp);
		tcp_fabric_model_i.set_kill(1'h1);
		@(posedge aclk);
		chk("kill cmp", 0, cmp);
		tcp_fabric_model_i.set_kill(1'h0);
		n = 5 + $urandom % 16;
		tcp_fabric_model_i.en_for(n);
		rchk("gated", `TCP_A_COUNT, p - n);
		tcp_fabric_model_i.pulse(1'h1);
		rchk("capture", `TCP_A_CAPTURE, p - n);
		rd_reg(`TCP_A_INTSTAT, rd);
		chk("cap flag", 1, rd[2]);
		tcp_fabric_model_i.pulse(1'h0);
		rchk("reload", `TCP_A_COUNT, p);
		// interrupt raise, mask and clear
		wr(`TCP_A_INTSTAT, 32'h7);
		rchk("int clear", `TCP_A_INTSTAT, 32'h0);
		wr(`TCP_A_INTMASK, 32'h4);
		tcp_fabric_model_i.pulse(1'h1);
		repeat (3) @(posedge aclk);
		chk("irq on", 1, irq);
		wr(`TCP_A_INTMASK, 32'h0);
		chk("irq mask", 0, irq);
		// capture stays unmasked so a failed clear would show on irq
		wr(`TCP_A_INTMASK, 32'h5);
		wr(`TCP_A_INTSTAT, 32'h4);
		ce <= 1'h0;
		repeat (3) @(posedge aclk);
		ce <= 1'h1;
		chk("irq clr", 0, irq);
		// period in cycles for the clock and prescale sources
		q = 3 + $urandom % 8;
		k = $urandom % 4;
		wr(`TCP_A_CTRL, 32'h0);
		wr(`TCP_A_PERIOD, q);
		wr(`TCP_A_PRESCALE, k);
		for (int s = 0; s < 2; s++) begin
			wr(`TCP_A_INTSTAT, 32'h7);
			wr(`TCP_A_CTRL, 32'h1 | (s << 6));
			base = tc_cnt;
			repeat (400) if (tc_cnt < base + 3) @(posedge aclk);
			chk("tc gap", (q + 1) * (s ? k + 1 : 1), tc_gap);
			chk("irq tc", 1, irq);
			wr(`TCP_A_CTRL, 32'h0);
		end
		// external edges, rising then falling
		for (int s = 2; s < 4; s++) begin
			wr(`TCP_A_CTRL, 32'h1 | (s << 6));
			base = tc_cnt;
			tcp_fabric_model_i.ext_ticks(q + 1, $urandom % 3);
			repeat (4) @(posedge aclk);
			chk("ext tc", 1, tc_cnt - base);
			wr(`TCP_A_CTRL, 32'h0);
		end
		wr(`TCP_A_CTRL, 32'h3);
		base = tc_cnt;
		repeat (3 * q + 20) @(posedge aclk);
		chk("oneshot tc", 1, tc_cnt - base);
		rd_reg(`TCP_A_STATUS, rd);
		chk("oneshot done", 4, rd[2:0]);
		// complementary pair with dead band
		db = 2 + $urandom % 8;
		wr(`TCP_A_PERIOD, 40);
		wr(`TCP_A_COMPARE, 20);
		wr(`TCP_A_DEADBAND, db);
		// low lane not strobed, so the gap length must survive
		wstrb <= 4'hE;
		wr(`TCP_A_DEADBAND, 32'hFF);
		wstrb <= 4'hF;
		rchk("strobe", `TCP_A_DEADBAND, db);
		// start bit needed: the one-shot is parked in done with enable still set
		wr(`TCP_A_CTRL, 32'h301);
		compl_on = 1'h1;
		repeat (300) @(posedge aclk);
		compl_on = 1'h0;
		chk("overlap", 0, ovl);
		chk("dead gap", 1, min_gap >= db && min_gap < 999);
		print_verdict();
	end
endmodule // tcp_timer_tb_top
`default_nettype wire
